/* rtl/emru_pkg.sv */
// Constants and carrier types are declared with the unloader's top level

/* rtl/emru_fifo.sv */
// The record buffer module is declared with the unloader's top level

/* rtl/emru_unloader.sv */
// Error message unloader: constants, record buffer and top level
//
// How it works
// - One clock, reset returns everything to idle.
// - Register update triggers serial unload, deserialize.
// - Reread request starts a fresh unload.
// - Register keeps last error, reread repeats it.
// - Fault flag synchronized into unloader clock.
// - Separate fault pin follows the same synchronized fault flag.
// - Verify part shares the unloader clock and reset.
// - Word width is 78; 46 and 67 are declared but unused.
// - Valid only with complete unloaded record.
// - Lost flag marks a record missed by overrun.
// - Scan done marks each full-chip pass.
// - Unload takes two plus N+3 cycles.
// - Three-bit type: zero frame, ones uncorrectable.
// - One frame pass, then column checking forever.
// - Overwritten record before delivery flags lost.
// - Next fault falling before capture flags lost.
// - Fault flag rising edge clears lost.
`timescale 1ns/100ps
package emru_pkg;

  // ----------------------------------------------------------------
  // Word widths and timing
  // ----------------------------------------------------------------
  localparam int EMRU_WIDTH_SMALL = 46;
  localparam int EMRU_WIDTH_MID = 67;
  localparam int EMRU_WIDTH_LARGE = 78;
  localparam int EMRU_WIDTH = EMRU_WIDTH_LARGE;
  localparam int EMRU_HARD_CYCLES = 2;
  localparam int EMRU_EXTRA_CYCLES = 3;
  localparam int EMRU_UNLOAD_CYCLES = EMRU_WIDTH + EMRU_EXTRA_CYCLES;
  localparam int EMRU_CNT_W = 7;
  localparam int EMRU_FIFO_DEPTH = 16;
  localparam int EMRU_FIFO_AW = 4;

  // ----------------------------------------------------------------
  // Error type field
  // ----------------------------------------------------------------
  localparam int EMRU_TYPE_LSB = 0;
  localparam int EMRU_TYPE_W = 3;
  localparam logic [2:0] EMRU_TYPE_FRAME = 3'h0;
  localparam logic [2:0] EMRU_TYPE_UNCORR = 3'h7;

  // Error classes decoded from the type field
  typedef enum logic [1:0] {
    EMRU_CLASS_FRAME,
    EMRU_CLASS_CORR,
    EMRU_CLASS_UNCORR
  } emru_class_t;

  // Carrier of one unloaded record
  typedef struct packed {
    logic lost;
    emru_class_t err_class;
    logic [EMRU_WIDTH-1:0] word;
  } emru_rec_t;

  localparam int EMRU_REC_W = $bits(emru_rec_t);

  // Classify a record by its type field
  function automatic emru_class_t emru_classify(input logic [2:0] t);
    if (t == EMRU_TYPE_FRAME)
      return EMRU_CLASS_FRAME;
    else if (t == EMRU_TYPE_UNCORR)
      return EMRU_CLASS_UNCORR;
    else
      return EMRU_CLASS_CORR;
  endfunction : emru_classify

endpackage : emru_pkg

// ----------------------------------------------------------------
// Record buffer
// ----------------------------------------------------------------
module emru_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire logic full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire logic empty = (wr_reg == rd_reg);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rd_reg[AW-1:0]];

  // Storage write
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
  end

  // Pointers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end

endmodule : emru_fifo

module emru_unloader
  import emru_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reread_i,
  input wire logic fault_flag_raw_i,
  input wire logic update_raw_i,
  input wire logic scan_done_raw_i,
  input wire logic serial_data_i,
  output logic serial_shift_o,
  output logic serial_load_o,
  output logic fault_flag_o,
  output logic fault_pin_o,
  output logic scan_done_o,
  output logic [EMRU_WIDTH-1:0] msg_word_o,
  output logic [1:0] msg_class_o,
  output logic msg_valid_o,
  output logic msg_lost_o,
  input wire logic msg_ready_i
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic fault_d_reg;
  logic update_d_reg;
  logic scan_d_reg;
  wire logic [3:0] raw_in = {serial_data_i, scan_done_raw_i, update_raw_i, fault_flag_raw_i};
  wire logic fault_s = sync2_reg[0];
  wire logic update_s = sync2_reg[1];
  wire logic scan_s = sync2_reg[2];
  wire logic sdata_s = sync2_reg[3];
  wire logic fault_rise = fault_s && !fault_d_reg;
  wire logic fault_fall = !fault_s && fault_d_reg;
  wire logic update_rise = update_s && !update_d_reg;

  // Two-stage capture of the fault, update, scan done and serial data inputs
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      fault_d_reg <= 1'b0;
      update_d_reg <= 1'b0;
      scan_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      fault_d_reg <= fault_s;
      update_d_reg <= update_s;
      scan_d_reg <= scan_s;
    end
  end

  // ----------------------------------------------------------------
  // Unload sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EMRU_IDLE,
    EMRU_LOAD,
    EMRU_SHIFT,
    EMRU_DONE
  } emru_state_t;

  emru_state_t state_reg;
  emru_state_t state_next;
  logic [EMRU_CNT_W-1:0] cnt_reg;
  logic [EMRU_WIDTH-1:0] shift_reg;
  logic pending_reg;
  logic lost_reg;
  wire logic start_req = update_rise || reread_i || pending_reg;
  wire logic last_cnt = (cnt_reg == EMRU_CNT_W'(EMRU_UNLOAD_CYCLES - 1));
  wire logic launch = (state_reg == EMRU_IDLE) && (state_next == EMRU_LOAD);
  // Queued update overwritten, or next fault pulse ends before it loads
  wire logic overrun = pending_reg && !launch && (update_rise || fault_fall);
  // Serial bits reach sdata_s two cycles late, so skip the first two
  wire logic shift_win = (cnt_reg >= EMRU_CNT_W'(EMRU_HARD_CYCLES))
    && (cnt_reg < EMRU_CNT_W'(EMRU_HARD_CYCLES + EMRU_WIDTH));
  wire logic rec_done = (state_reg == EMRU_DONE);
  wire logic in_ready;
  wire logic [EMRU_TYPE_W-1:0] rec_type = shift_reg[EMRU_TYPE_LSB +: EMRU_TYPE_W];

  // Next state selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      EMRU_IDLE: if (start_req && in_ready) state_next = EMRU_LOAD;
      EMRU_LOAD: state_next = EMRU_SHIFT;
      EMRU_SHIFT: if (last_cnt) state_next = EMRU_DONE;
      EMRU_DONE: state_next = EMRU_IDLE;
      default: state_next = EMRU_IDLE;
    endcase
  end

  // Sequencer, counter and deserialiser
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= EMRU_IDLE;
      cnt_reg <= '0;
      shift_reg <= '0;
      serial_shift_o <= 1'b0;
      serial_load_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      serial_load_o <= (state_next == EMRU_LOAD);
      serial_shift_o <= (state_next == EMRU_SHIFT);
      if (state_reg == EMRU_LOAD)
        cnt_reg <= '0;
      else if (state_reg == EMRU_SHIFT)
        cnt_reg <= cnt_reg + 1'b1;
      if (state_reg == EMRU_SHIFT && shift_win)
        shift_reg <= {sdata_s, shift_reg[EMRU_WIDTH-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // Pending update and lost-record tracking
  // ----------------------------------------------------------------
  // An update that cannot start at once is queued; overwriting it loses a record
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pending_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else
    begin
      if (update_rise && !launch)
        pending_reg <= 1'b1;
      else if (launch)
        pending_reg <= 1'b0;
      if (overrun)
        lost_reg <= 1'b1;
      else if (fault_rise)
        lost_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  emru_rec_t rec_in;
  emru_rec_t rec_out;
  wire logic out_valid;
  wire logic [EMRU_REC_W-1:0] rec_out_bits;
  wire logic take = out_valid && (msg_ready_i || !msg_valid_o);

  assign rec_in.lost = lost_reg;
  assign rec_in.err_class = emru_classify(rec_type);
  assign rec_in.word = shift_reg;
  assign rec_out = emru_rec_t'(rec_out_bits);

  emru_fifo #(
    .WIDTH(EMRU_REC_W),
    .DEPTH(EMRU_FIFO_DEPTH),
    .AW(EMRU_FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rec_done),
    .in_ready_o(in_ready),
    .in_data_i(rec_in),
    .out_valid_o(out_valid),
    .out_ready_i(take),
    .out_data_o(rec_out_bits)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Valid pulses once per record, word holds until the next one
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      msg_word_o <= '0;
      msg_class_o <= 2'h0;
      msg_valid_o <= 1'b0;
      msg_lost_o <= 1'b0;
      fault_flag_o <= 1'b0;
      fault_pin_o <= 1'b0;
      scan_done_o <= 1'b0;
    end
    else
    begin
      msg_valid_o <= take;
      if (take)
      begin
        msg_word_o <= rec_out.word;
        msg_class_o <= rec_out.err_class;
      end
      if (take && rec_out.lost)
        msg_lost_o <= 1'b1;
      else if (fault_rise)
        msg_lost_o <= 1'b0;
      fault_flag_o <= fault_s;
      fault_pin_o <= fault_s;
      scan_done_o <= scan_s && !scan_d_reg;
    end
  end

endmodule : emru_unloader

/* sim/emru_unloader_assertions.sv */
// Port checker for the error message unloader
`timescale 1ns/100ps
module emru_chk
  import emru_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic fault_flag_raw_i,
  input wire logic scan_done_raw_i,
  input wire logic serial_shift_o,
  input wire logic serial_load_o,
  input wire logic fault_flag_o,
  input wire logic scan_done_o,
  input wire logic [EMRU_WIDTH-1:0] msg_word_o,
  input wire logic [1:0] msg_class_o,
  input wire logic msg_valid_o,
  input wire logic msg_lost_o
);
  logic [7:0] run_reg;
  logic [2:0] ty;
  logic [1:0] cls;
  // Expected class and length of the shift run
  assign ty = msg_word_o[2:0];
  assign cls = ty == 3'h0 ? 2'h0 : (ty == 3'h7 ? 2'h2 : 2'h1);
  always_ff @(posedge sys_clk_i)
    run_reg <= serial_shift_o ? run_reg + 8'h01 : 8'h00;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  rst_idle_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !msg_valid_o && !msg_lost_o && !serial_shift_o) else $error("reset");
  load_shift_a: assert property (serial_load_o |=> serial_shift_o && !serial_load_o)
    else $error("load");
  shift_len_a: assert property ($fell(serial_shift_o) |-> run_reg == 8'h51)
    else $error("shift length");
  word_hold_a: assert property (!msg_valid_o |-> $stable({msg_class_o, msg_word_o}))
    else $error("word hold");
  class_map_a: assert property (msg_valid_o |-> msg_class_o == cls)
    else $error("class");
  lost_clear_a: assert property (
    $rose(fault_flag_o) && $past(msg_lost_o) |-> !msg_lost_o) else $error("lost clear");
  flag_sync_a: assert property ($rose(fault_flag_raw_i) |-> ##[1:4] fault_flag_o)
    else $error("flag sync");
  scan_pulse_a: assert property (
    $rose(scan_done_raw_i) |-> ##[1:4] scan_done_o ##1 !scan_done_o) else $error("scan");
endmodule : emru_chk

bind emru_unloader emru_chk chk_u (.sys_clk_i, .rst_n_i, .fault_flag_raw_i, .scan_done_raw_i,
  .serial_shift_o, .serial_load_o, .fault_flag_o, .scan_done_o, .msg_word_o, .msg_class_o,
  .msg_valid_o, .msg_lost_o);

/* sim/emru_hard_model.sv */
// Model of the hard message register and its serial port
`timescale 1ns/100ps
module emru_hard_model
  import emru_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic load_i,
  input wire logic shift_i,
  input wire logic [EMRU_WIDTH-1:0] msg_i,
  output logic serial_data_o
);
  logic [EMRU_WIDTH-1:0] sreg_reg;
  // Load the held record, shift LSB first, scramble when idle
  always_ff @(posedge sys_clk_i)
  begin
    if (load_i)
      sreg_reg <= msg_i;
    else if (shift_i)
      sreg_reg <= {~sreg_reg[0], sreg_reg[EMRU_WIDTH-1:1]};
    else
      sreg_reg <= ~sreg_reg;
  end
  assign serial_data_o = sreg_reg[0];
endmodule : emru_hard_model

/* sim/testbench.sv */
// Self-checking bench for the error message unloader
`timescale 1ns/100ps
module testbench
  import emru_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd = 1'b0, flt = 1'b0, upd = 1'b0, scr = 1'b0, rdy = 1'b1;
  logic sdat, shft, ld, vld, lost, ffo, fpo, sdo;
  logic [1:0] cls;
  logic [EMRU_WIDTH-1:0] word, msg = '0;
  logic [EMRU_WIDTH+1:0] exp_q[$];
  int fail_count = 0;
  int samples_checked = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  emru_unloader dut_u (.sys_clk_i, .rst_n_i, .reread_i(rd), .fault_flag_raw_i(flt),
    .update_raw_i(upd), .scan_done_raw_i(scr), .serial_data_i(sdat), .serial_shift_o(shft),
    .serial_load_o(ld), .fault_flag_o(ffo), .fault_pin_o(fpo), .scan_done_o(sdo),
    .msg_word_o(word), .msg_class_o(cls), .msg_valid_o(vld), .msg_lost_o(lost),
    .msg_ready_i(rdy));
  emru_hard_model far_u (.sys_clk_i, .load_i(ld), .shift_i(shft), .msg_i(msg),
    .serial_data_o(sdat));
  task automatic check(string what, logic [EMRU_WIDTH+1:0] e, logic [EMRU_WIDTH+1:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // New random record on an update, or a reread of the held one
  task automatic unload(logic [2:0] t, logic fresh);
    if (fresh)
      msg = {(EMRU_WIDTH-3)'({$urandom(), $urandom(), $urandom()}), t};
    exp_q.push_back({(t == 3'h0 ? 2'h0 : (t == 3'h7 ? 2'h2 : 2'h1)), msg});
    rd = ~fresh;
    upd = fresh;
    @(negedge sys_clk_i);
    rd = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    upd = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : unload
  // Bounded wait until every noted record is seen
  task automatic drain(output int n);
    for (n = 0; exp_q.size() > 0; n++)
    begin
      @(negedge sys_clk_i);
      if (n == 3000)
      begin
        check("drain", 0, 1);
        stop_test();
      end
    end
  endtask : drain
  // Compare each delivered record with the oldest note, or with the held record when no note is left, mid-cycle while valid stands
  always @(negedge sys_clk_i)
  begin
    if (vld === 1'b1 && exp_q.size() > 0)
      check("record", exp_q.pop_front(), {cls, word});
    else if (vld === 1'b1)
      check("reread", msg, word);
  end
  // Main sequence
  initial
  begin
    int n;
    void'($urandom(23055));
    repeat (16) @(negedge sys_clk_i);
    check("reset", 0, {sdo, fpo, ffo, lost, vld, shft, ld});
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      unload(3'(i), 1'b1);
      drain(n);
      check("latency", 1, n inside {[EMRU_UNLOAD_CYCLES-12:EMRU_UNLOAD_CYCLES+6]});
    end
    unload(msg[2:0], 1'b0);
    drain(n);
    // Consumer drops ready, yet valid still pulses once per record so the buffer never fills
    rdy = 1'b0;
    for (int i = 0; i < EMRU_FIFO_DEPTH; i++)
    begin
      unload(3'(i), 1'b1);
      repeat (90) @(negedge sys_clk_i);
    end
    rdy = 1'b1;
    drain(n);
    // Errors back to back with the flag high, then the flag drops
    flt = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      upd = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      upd = 1'b0;
      repeat (4) @(negedge sys_clk_i);
    end
    flt = 1'b0;
    repeat (300) @(negedge sys_clk_i);
    check("lost", 1, lost);
    check("flag low", 0, {fpo, ffo});
    flt = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check("lost clear", 0, lost);
    check("flag high", 3, {fpo, ffo});
    // Scan done held six cycles must give exactly one output pulse
    n = 0;
    for (int i = 0; i < 10; i++)
    begin
      scr = (i < 6);
      @(negedge sys_clk_i);
      if (sdo === 1'b1)
        n++;
    end
    check("scan pulse", 1, n == 1);
    stop_test();
  end
endmodule : testbench
